// [logic/ssp_regs.svh]
`ifndef SSP_REGS_SVH
`define SSP_REGS_SVH

// Frame width in bits
`define SSP_DATA_W     8
// Clock edges in one frame
`define SSP_EDGES      16
// Last edge index of a frame
`define SSP_LAST_EDGE  4'hF
// Core clock rate in Hz
`define SSP_CORE_HZ    50000000
// Least core cycles per half period of the master clock
`define SSP_MIN_HALF   1
// Least ratio of core clock to external slave clock
`define SSP_SLV_RATIO  10
// Synchroniser width: sck, data in (slave), data in (master), select
`define SSP_SYNC_W     4

`endif

// [logic/ssp_pkg.sv]
package ssp_pkg;

  // Static configuration of the port
  typedef struct packed {
    logic       enable;    // Port enabled
    logic       master;    // 1 master, 0 slave
    logic       four_wire; // 1 select line in use
    logic       ss_drive;  // Master: select line is an output
    logic       ss_level;  // Level driven on the select output
    logic       cpol;      // Idle clock level
    logic       cpha;      // 1 sample on trailing edge
    logic [7:0] clk_div;   // Half period minus one, in core cycles
  } ssp_cfg_t;

  // Status seen by software
  typedef struct packed {
    logic busy;       // Frame in progress
    logic mode_fault; // Sticky: master blocked by foreign select
  } ssp_stat_t;

  // Frame sequencer states
  typedef enum logic {
    SSP_IDLE,
    SSP_RUN
  } ssp_state_t;

endpackage : ssp_pkg

// [logic/ssp_port.sv]
`timescale 1ns/1ns
`include "ssp_regs.svh"
module ssp_port
  import ssp_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       resetn_i,
  // Configuration and status
  input  wire ssp_cfg_t   cfg_i,
  input  wire logic       fault_clear_i,
  output ssp_stat_t       stat_o,
  // Byte interface
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_valid_i,
  output logic            tx_ready_o,
  output logic [7:0]      rx_data_o,
  output logic            done_o,
  // Serial clock pin
  input  wire logic       sck_i,
  output logic            sck_o,
  output logic            sck_oe_o,
  // Master-out data pin
  input  wire logic       mosi_i,
  output logic            mosi_o,
  output logic            mosi_oe_o,
  // Master-in data pin
  input  wire logic       miso_i,
  output logic            miso_o,
  output logic            miso_oe_o,
  // Slave select line pin
  input  wire logic       ss_n_i,
  output logic            ss_n_o,
  output logic            ss_n_oe_o
);

  // Pin synchronisers
  logic [`SSP_SYNC_W-1:0] sync_meta;   // First stage, read only by second
  logic [`SSP_SYNC_W-1:0] sync_q;      // Second stage, safe to use
  logic                   sck_prev;    // Previous synced clock level

  // Sequencer state
  ssp_state_t state,    next_state;    // Frame state
  logic [7:0] div_cnt,  next_div_cnt;  // Rate generator count
  logic [3:0] edge_cnt, next_edge_cnt; // Clock edges seen in frame
  logic       sck,      next_sck;      // Master clock level
  logic [7:0] sreg,     next_sreg;     // Transmit shifter
  logic [7:0] rx_sh,    next_rx_sh;    // Receive shifter
  logic       out_bit,  next_out_bit;  // Bit on the data output
  logic [7:0] tx_buf,   next_tx_buf;   // Byte held for next frame
  logic [7:0] rx_data,  next_rx_data;  // Last received byte
  logic       done,     next_done;     // Completion pulse
  logic       fault,    next_fault;    // Sticky mode fault

  // Decoded conditions
  logic s_sck, s_mosi, s_miso, s_ss_n;
  logic is_master, is_slave, ss_in_use, foreign_sel, selected;
  logic edge_ev, lead, sample, rx_bit, tick;

  assign s_sck  = sync_q[0];
  assign s_mosi = sync_q[1];
  assign s_miso = sync_q[2];
  assign s_ss_n = sync_q[3];

  // Role decode
  assign is_master   = cfg_i.enable & cfg_i.master;
  assign is_slave    = cfg_i.enable & ~cfg_i.master;
  // Select line is only an input in 4-wire form without output drive
  assign ss_in_use   = cfg_i.four_wire & ~(cfg_i.master & cfg_i.ss_drive);
  assign foreign_sel = is_master & ss_in_use & ~s_ss_n;
  // 3-wire slave is always selected while enabled
  assign selected    = is_slave & (~cfg_i.four_wire | ~s_ss_n);

  // Rate generator tick every clk_div+1 core cycles
  assign tick = (div_cnt == cfg_i.clk_div);

  // Clock edge event and its kind
  always_comb begin
    edge_ev = 1'b0;
    lead    = 1'b0;
    if (is_master) begin
      // Even edge counts are leading edges
      edge_ev = (state == SSP_RUN) & tick;
      lead    = ~edge_cnt[0];
    end else if (selected) begin
      // Slave follows the external clock
      lead    = (s_sck != cfg_i.cpol);
      // Idle slave waits for a leading edge, so a stray return to idle
      // level after reset or a role change cannot start a frame
      edge_ev = (s_sck != sck_prev) & ((state == SSP_RUN) | lead);
    end
  end

  // Sample on leading edge in phase 0, trailing edge in phase 1
  assign sample = lead ^ cfg_i.cpha;
  assign rx_bit = is_master ? s_miso : s_mosi;

  // Next-state logic of the sequencer
  always_comb begin
    next_state    = state;
    next_div_cnt  = div_cnt;
    next_edge_cnt = edge_cnt;
    next_sck      = sck;
    next_sreg     = sreg;
    next_rx_sh    = rx_sh;
    next_out_bit  = out_bit;
    next_tx_buf   = tx_buf;
    next_rx_data  = rx_data;
    next_done     = 1'b0;
    // Fault: set wins over clear
    next_fault    = (fault & ~fault_clear_i) | foreign_sel;
    case (state)
      SSP_IDLE: begin
        next_div_cnt  = 8'h00;
        next_edge_cnt = 4'h0;
        next_sck      = cfg_i.cpol;
        // Accept a byte for the next frame
        if (tx_valid_i) begin
          next_tx_buf = tx_data_i;
        end
        if (is_master) begin
          // Master starts a frame on a new byte unless blocked
          if (tx_valid_i & ~fault & ~foreign_sel) begin
            next_state = SSP_RUN;
            if (cfg_i.cpha) begin
              next_sreg = tx_data_i;
            end else begin
              // Phase 0: first bit leads the first edge
              next_out_bit = tx_data_i[7];
              next_sreg    = {tx_data_i[6:0], 1'b0};
            end
          end
        end else begin
          // Slave keeps its shifter preloaded while idle
          if (cfg_i.cpha) begin
            next_sreg = next_tx_buf;
          end else begin
            next_out_bit = next_tx_buf[7];
            next_sreg    = {next_tx_buf[6:0], 1'b0};
          end
          if (edge_ev) begin
            next_state = SSP_RUN;
          end
        end
      end
      SSP_RUN: begin
        if (is_master) begin
          next_div_cnt = tick ? 8'h00 : div_cnt + 8'h01;
          if (tick) begin
            next_sck = ~sck;
          end
        end
        // Abort on blocking, deselect or disable
        if (foreign_sel | ~(is_master | selected)) begin
          next_state = SSP_IDLE;
        end
      end
      default: begin
        next_state = SSP_IDLE;
      end
    endcase
    // Shift and sample on each clock edge of the frame
    if (edge_ev & ~foreign_sel) begin
      next_edge_cnt = edge_cnt + 4'h1;
      if (sample) begin
        next_rx_sh = {rx_sh[6:0], rx_bit};
      end else begin
        next_out_bit = next_sreg[7];
        next_sreg    = {next_sreg[6:0], 1'b0};
      end
      // Sixteen edges close one byte each way
      if (edge_cnt == `SSP_LAST_EDGE) begin
        next_state    = SSP_IDLE;
        next_rx_data  = next_rx_sh;
        next_done     = 1'b1;
        next_edge_cnt = 4'h0;
      end
    end
  end

  // Synchroniser registers
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync_meta <= 4'hF;
      sync_q    <= 4'hF;
      // Same level as the synchroniser reset, so no edge right after reset
      sck_prev  <= 1'b1;
    end else begin
      sync_meta <= {ss_n_i, miso_i, mosi_i, sck_i};
      sync_q    <= sync_meta;
      sck_prev  <= s_sck;
    end
  end

  // Sequencer registers
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state    <= SSP_IDLE;
      div_cnt  <= 8'h00;
      edge_cnt <= 4'h0;
      sck      <= 1'b0;
      sreg     <= 8'h00;
      rx_sh    <= 8'h00;
      out_bit  <= 1'b0;
      tx_buf   <= 8'h00;
      rx_data  <= 8'h00;
      done     <= 1'b0;
      fault    <= 1'b0;
    end else begin
      state    <= next_state;
      div_cnt  <= next_div_cnt;
      edge_cnt <= next_edge_cnt;
      sck      <= next_sck;
      sreg     <= next_sreg;
      rx_sh    <= next_rx_sh;
      out_bit  <= next_out_bit;
      tx_buf   <= next_tx_buf;
      rx_data  <= next_rx_data;
      done     <= next_done;
      fault    <= next_fault;
    end
  end

  // Byte interface outputs
  assign tx_ready_o        = (state == SSP_IDLE);
  assign rx_data_o         = rx_data;
  assign done_o            = done;
  assign stat_o.busy       = (state == SSP_RUN);
  assign stat_o.mode_fault = fault;

  // Master drives clock and data unless faulted
  assign sck_o     = sck;
  assign sck_oe_o  = is_master & ~fault;
  assign mosi_o    = out_bit;
  assign mosi_oe_o = is_master & ~fault;
  // Slave drives its data only while selected
  assign miso_o    = out_bit;
  assign miso_oe_o = selected;
  // Select output level set by firmware
  assign ss_n_o    = cfg_i.ss_level;
  assign ss_n_oe_o = is_master & cfg_i.four_wire & cfg_i.ss_drive;

endmodule : ssp_port

// [test/ssp_port_asserts.sv]
`timescale 1ns/1ns
module ssp_port_asserts
  import ssp_pkg::*;
(
  // Watched ports
  input wire logic      mclk_i,
  input wire logic      resetn_i,
  input wire ssp_cfg_t  cfg_i,
  input wire logic      fault_clear_i,
  input wire ssp_stat_t stat_o,
  input wire logic      tx_valid_i,
  input wire logic      tx_ready_o,
  input wire logic      done_o,
  input wire logic      sck_o,
  input wire logic      sck_oe_o,
  input wire logic      mosi_oe_o,
  input wire logic      ss_n_i,
  input wire logic      ss_n_o,
  input wire logic      ss_n_oe_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  // Enabled as master
  wire m_on = cfg_i.enable && cfg_i.master;
  chk_take_start: assert property (tx_valid_i && tx_ready_o && m_on
    && !stat_o.mode_fault && (cfg_i.ss_drive || !cfg_i.four_wire) |=> stat_o.busy)
    else $error("byte not taken");
  chk_done_pulse: assert property (done_o |=> !done_o) else $error("long done");
  chk_fault_set: assert property (
    (m_on && cfg_i.four_wire && !cfg_i.ss_drive && !ss_n_i)[*3] |-> ##[1:2] stat_o.mode_fault)
    else $error("no mode fault");
  chk_fault_pins: assert property (
    stat_o.mode_fault |-> !sck_oe_o && !mosi_oe_o) else $error("faulted master drives");
  chk_fault_hold: assert property (
    stat_o.mode_fault && !fault_clear_i |=> stat_o.mode_fault) else $error("fault lost");
  chk_ss_follow: assert property (m_on && cfg_i.four_wire && cfg_i.ss_drive
    |-> ss_n_oe_o && ss_n_o == cfg_i.ss_level) else $error("select output wrong");
  chk_ss_unused: assert property (
    !cfg_i.four_wire |-> !ss_n_oe_o) else $error("select driven");
  chk_sck_idle: assert property (
    (m_on && !stat_o.busy && $stable(cfg_i.cpol))[*2] |-> sck_o == cfg_i.cpol)
    else $error("idle clock level");
endmodule : ssp_port_asserts
bind ssp_port ssp_port_asserts u_chk (.mclk_i(mclk_i), .resetn_i(resetn_i), .cfg_i(cfg_i),
  .fault_clear_i(fault_clear_i), .stat_o(stat_o), .tx_valid_i(tx_valid_i),
  .tx_ready_o(tx_ready_o), .done_o(done_o), .sck_o(sck_o), .sck_oe_o(sck_oe_o),
  .mosi_oe_o(mosi_oe_o), .ss_n_i(ss_n_i), .ss_n_o(ss_n_o), .ss_n_oe_o(ss_n_oe_o));

// [test/ssp_far_slave.sv]
`timescale 1ns/1ns
module ssp_far_slave (
  // Pins and mode
  input  wire logic       sck_i,
  input  wire logic       mosi_i,
  input  wire logic       ss_n_i,
  input  wire logic       cpol_i,
  input  wire logic       cpha_i,
  input  wire logic [7:0] tx_i,
  output logic [7:0]      rx_o,
  output logic            miso_o
);
  logic [7:0] sh; // Reply bits left
  logic       q;  // Bit on the line
  // Released line shows the inverse bit
  assign miso_o = ss_n_i ? ~q : q;
  // Reply loads at select
  always @(negedge ss_n_i) {sh, q} = {tx_i, tx_i[7]};
  // Shift on one edge, sample on the other
  always @(sck_i) begin
    if (!ss_n_i && ((sck_i != cpol_i) == cpha_i)) begin
      if (cpha_i) q = sh[7];
      sh = sh << 1;
      if (!cpha_i) q = sh[7];
    end else if (!ss_n_i) begin
      rx_o = {rx_o[6:0], mosi_i};
    end
  end
endmodule : ssp_far_slave

// [test/test_ssp_port.sv]
`timescale 1ns/1ns
module test_ssp_port;
  import ssp_pkg::*;
  logic       mclk_i, resetn_i, fclr, tx_valid, tx_ready, done; // Control
  ssp_cfg_t   cfg;                                             // Port setup
  ssp_stat_t  stat;                                            // Port status
  logic [7:0] tx_data, rx_data, stx, m_rx, got;                // Bytes
  logic       sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_o, ss_oe;
  logic       t_sck, t_mosi, t_ss_n, m_miso;                   // Far-side drives
  int         failures, checked;                               // Counters
  // Resolved pin levels
  wire sck = sck_oe ? sck_o : t_sck;
  wire mosi = mosi_oe ? mosi_o : t_mosi;
  wire miso = miso_oe ? miso_o : m_miso;
  wire ss_n = ss_oe ? ss_o : t_ss_n;
  ssp_port i_dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .cfg_i(cfg), .fault_clear_i(fclr),
    .stat_o(stat), .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready),
    .rx_data_o(rx_data), .done_o(done), .sck_i(sck), .sck_o(sck_o), .sck_oe_o(sck_oe),
    .mosi_i(mosi), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe), .miso_i(miso), .miso_o(miso_o),
    .miso_oe_o(miso_oe), .ss_n_i(ss_n), .ss_n_o(ss_o), .ss_n_oe_o(ss_oe));
  ssp_far_slave i_far (.sck_i(sck), .mosi_i(mosi), .ss_n_i(ss_n), .cpol_i(cfg.cpol),
    .cpha_i(cfg.cpha), .tx_i(stx), .rx_o(m_rx), .miso_o(m_miso));
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  task automatic step;
    @(posedge mclk_i);
    #2;
  endtask : step
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  // Bounded wait for the completion pulse
  task automatic wait_done;
    int n;
    for (n = 0; n < 5000 && done !== 1'b1; n++) step();
    if (n == 5000) begin
      failures++;
      report_and_stop();
    end
  endtask : wait_done
  // One master frame against the far slave
  task automatic xfer(input logic [7:0] m, input logic [7:0] s);
    {cfg.ss_level, t_ss_n, stx} = {2'b11, s};
    repeat (3) step();
    {cfg.ss_level, t_ss_n, tx_data, tx_valid} = {2'b00, m, 1'b1};
    step();
    tx_valid = 1'b0;
    check(tx_ready, 1'b0);
    wait_done();
    check(rx_data, s);
    check(m_rx, m);
  endtask : xfer
  initial begin
    {cfg, fclr, tx_valid, tx_data, stx, got, t_sck, t_mosi, resetn_i} = '0;
    t_ss_n = 1'b1;
    failures = 0;
    checked = 0;
    repeat (16) step();
    resetn_i = 1'b1;
    {cfg.enable, cfg.master, cfg.four_wire, cfg.ss_drive, cfg.clk_div} = {4'hF, 8'h03};
    for (int md = 0; md < 4; md++) begin
      {cfg.cpol, cfg.cpha} = md[1:0];
      xfer(8'hA5 ^ md[7:0], 8'h3C + md[7:0]);
    end
    {cfg.four_wire, cfg.clk_div} = {1'b0, 8'hFF};
    xfer(8'hC3, 8'h5A);
    // Foreign master claims the select line
    {cfg.four_wire, cfg.ss_drive, cfg.clk_div, t_ss_n} = {2'b10, 8'h03, 1'b0};
    repeat (5) step();
    check(stat.mode_fault, 1'b1);
    check(sck_oe, 1'b0);
    {t_ss_n, fclr} = 2'b11;
    repeat (4) step();
    fclr = 1'b0;
    check(stat.mode_fault, 1'b0);
    // Full-rate master frame: half period of one core cycle
    {cfg.ss_drive, cfg.cpol, cfg.cpha, cfg.clk_div, cfg.ss_level} = {3'b100, 8'h00, 1'b1};
    repeat (3) step();
    {cfg.ss_level, tx_data, tx_valid} = {1'b0, 8'h69, 1'b1};
    step();
    tx_valid = 1'b0;
    repeat (15) step();
    check(done, 1'b0);
    step();
    check(done, 1'b1);
    check(m_rx, 8'h69);
    // Slave frame clocked by the bench below a tenth of the core rate
    cfg = '0;
    {cfg.enable, cfg.four_wire, tx_data, tx_valid, stx} = {2'b11, 8'h96, 1'b1, 8'h6B};
    step();
    {tx_valid, t_ss_n} = 2'b00;
    repeat (4) step();
    for (int i = 7; i >= 0; i--) begin
      t_mosi = stx[i];
      repeat (10) step();
      t_sck = 1'b1;
      got = {got[6:0], miso};
      repeat (10) step();
      t_sck = 1'b0;
    end
    wait_done();
    check(rx_data, 8'h6B);
    check(got, 8'h96);
    // Deselected slave must ignore clock edges
    t_ss_n = 1'b1;
    repeat (4) step();
    t_sck = 1'b1;
    repeat (4) step();
    check(stat.busy, 1'b0);
    check(miso_oe, 1'b0);
    t_sck = 1'b0;
    repeat (4) step();
    report_and_stop();
  end
endmodule : test_ssp_port
